// ---- hw/can_transceiver_mode_supervisor.sv ----
`timescale 1ns/100ps
`include "can_xcvr_cfg.svh"
// Notes on behaviour
// RULE_01: Receive-only disables driver, receiver stays on.
// RULE_02: Low battery: bus lines high impedance.
// RULE_03: Transceiver mode limited by chip mode.
// RULE_04: Own mode changes stay within allowed set.
// RULE_05: Sleep/stop: wake receiver replaces normal receiver.
// RULE_06: Wake during sleep command forces restart.
// RULE_07: Host selects wake-capable before sleep/stop.
// RULE_08: Host changes mode, sleep in separate commands.
// RULE_09: Wake in sleep moves chip to restart.
// RULE_10: All failures reported; time-out as TxD-ground. No code for supplyLow or regUndervoltage.
// RULE_11: Local failure or clamp forces receive-only.
// RULE_12: TxD time-out stops driver until SPI.
// RULE_13: Bus clamp: receive-only, flag, interrupt.
// RULE_14: TxD-RxD short inhibits driver, flags, interrupts.
// RULE_15: Host should cut transceiver supply on short.
// RULE_16: Overtemp off; resume after TxD recessive edge.
// RULE_17: RxD recessive clamp holds transmitter off.
// RULE_18: Uses regulator undervoltage; host may switch off.
// RULE_19: Bus short sets flag, interrupt, keeps mode.
// RULE_20: Host detects high-low line short itself.
// RULE_21: Split output on in normal, receive-only.
// RULE_22: Wake-capable re-armed only after other mode.
// RULE_23: Off mode ignores bus wake events.
// RULE_24: Time-outs are counters reset by recessive.
// RULE_25: Each inhibit latched; driver needs none set.
module can_transceiver_mode_supervisor
  import can_xcvr_pkg::*;
#(
  parameter int TXD_TO_CYC = `TXD_TIMEOUT_CYC,
  parameter int BUS_TO_CYC = `BUS_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Chip mode and SPI mode requests
  input wire chip_mode_e chipMode,
  input wire logic sleepCmdBusy,
  input wire logic modeReqValid,
  input wire xcvr_mode_e modeReq,
  // Event flag clear and interrupt mask
  input wire logic [`FLAG_COUNT-1:0] flagClear,
  input wire logic [`FLAG_COUNT-1:0] intMask,
  // Host and analog side
  input wire logic txdIn,
  input wire logic busDominant,
  input wire logic rxdSense,
  input wire logic busWake,
  input wire fault_in_s faults,
  // Analog controls
  output logic driveDominant_r,
  output logic normalRxEn_r,
  output logic wakeRxEn_r,
  output logic busHiZ_r,
  output logic splitEn_r,
  // Host and chip state machine
  output logic rxdOut_r,
  output logic intN_r,
  output logic restartReq_r,
  output xcvr_mode_e xcvrMode_r,
  output diag_e diagCode_r,
  output inhibit_s inhibit_r,
  output logic [`FLAG_COUNT-1:0] flags_r
);

  // ****************************************
  // Mode permission
  // ****************************************
  function automatic logic allowed(input chip_mode_e c, input xcvr_mode_e m);
    unique case (c)
      CHIP_INIT: allowed = (m == XCVR_OFF);
      CHIP_NORMAL: allowed = 1'b1;
      CHIP_STOP, CHIP_SLEEP, CHIP_RESTART: allowed = (m == XCVR_OFF) || (m == XCVR_WAKE);
      CHIP_FAILSAFE: allowed = (m == XCVR_WAKE);
      CHIP_SWFLASH: allowed = (m == XCVR_NORMAL);
      default: allowed = 1'b0;
    endcase
  endfunction : allowed

  function automatic xcvr_mode_e fallback(input chip_mode_e c);
    unique case (c)
      CHIP_INIT: fallback = XCVR_OFF;
      CHIP_SWFLASH: fallback = XCVR_NORMAL;
      default: fallback = XCVR_WAKE;
    endcase
  endfunction : fallback

  localparam int TW = $clog2(TXD_TO_CYC + 1);
  localparam int BW = $clog2(BUS_TO_CYC + 1);

  logic armed_r, armed_nxt;
  logic txdPrev_r, txdPrev_nxt;
  logic [TW-1:0] txdCnt_r, txdCnt_nxt;
  logic [BW-1:0] busCnt_r, busCnt_nxt;
  xcvr_mode_e xcvrMode_nxt;
  inhibit_s inhibit_nxt;
  diag_e diagCode_nxt;
  logic [`FLAG_COUNT-1:0] flags_nxt;
  logic driveDominant_nxt, normalRxEn_nxt, wakeRxEn_nxt, busHiZ_nxt, splitEn_nxt;
  logic rxdOut_nxt, intN_nxt, restartReq_nxt;
  logic reqOk, spiNormal, txdTo, busTo, wakeOk, rxClampNow, localFail, driverOk;
  logic [`FLAG_COUNT-1:0] flagSet;

  // ****************************************
  // Supervision next state
  // ****************************************
  always_comb begin
    // Wake-capable refused until the host has chosen another mode since the last wake
    reqOk = modeReqValid && allowed(chipMode, modeReq) && !(modeReq == XCVR_WAKE && !armed_r); // RULE_03 RULE_22
    spiNormal = reqOk && (modeReq == XCVR_NORMAL);
    // Counters restart on recessive and saturate at the limit
    txdCnt_nxt = txdIn ? '0 : (txdCnt_r == TW'(TXD_TO_CYC)) ? txdCnt_r : txdCnt_r + 1'b1; // RULE_24
    busCnt_nxt = !busDominant ? '0 : (busCnt_r == BW'(BUS_TO_CYC)) ? busCnt_r : busCnt_r + 1'b1; // RULE_24
    txdTo = !txdIn && (txdCnt_r == TW'(TXD_TO_CYC - 1));
    busTo = busDominant && (busCnt_r == BW'(BUS_TO_CYC - 1));
    rxClampNow = busDominant && rxdSense && normalRxEn_r;
    wakeOk = busWake && (xcvrMode_r == XCVR_WAKE) && armed_r; // RULE_23
    txdPrev_nxt = txdIn;

    inhibit_nxt = inhibit_r;
    if (spiNormal) begin
      inhibit_nxt.txdTimeout = 1'b0; // RULE_12
      inhibit_nxt.domClamp = 1'b0; // RULE_13
      inhibit_nxt.txRxShort = 1'b0; // RULE_14
      inhibit_nxt.rxdClamp = 1'b0; // RULE_17
    end
    if (txdTo) inhibit_nxt.txdTimeout = 1'b1; // RULE_12 RULE_25
    if (busTo) inhibit_nxt.domClamp = 1'b1; // RULE_13 RULE_25
    if (faults.txRxShort) inhibit_nxt.txRxShort = 1'b1; // RULE_14 RULE_25
    if (rxClampNow) inhibit_nxt.rxdClamp = 1'b1; // RULE_17 RULE_25
    // Released only by a recessive edge once cool, so no half bit leaks out
    if (faults.overTemp) begin
      inhibit_nxt.overTemp = 1'b1; // RULE_16
    end else if (txdIn && !txdPrev_r) begin
      inhibit_nxt.overTemp = 1'b0; // RULE_16
    end
    localFail = txdTo || faults.txRxShort || rxClampNow;

    xcvrMode_nxt = xcvrMode_r;
    if (reqOk) xcvrMode_nxt = modeReq; // RULE_01
    if ((localFail || busTo) && allowed(chipMode, XCVR_RXONLY)) begin
      xcvrMode_nxt = XCVR_RXONLY; // RULE_11 RULE_04
    end
    // Leaving normal chip mode drops a disallowed mode to off in init, normal in software flash, else wake-capable
    if (!allowed(chipMode, xcvrMode_nxt)) xcvrMode_nxt = fallback(chipMode); // RULE_03 RULE_05

    armed_nxt = armed_r;
    if (wakeOk) begin
      armed_nxt = 1'b0; // RULE_22
    end else if (reqOk && modeReq != XCVR_WAKE) begin
      armed_nxt = 1'b1; // RULE_22
    end
    // Wake during a sleep command overrides it; the chip state machine takes the request
    restartReq_nxt = wakeOk && (sleepCmdBusy || chipMode == CHIP_SLEEP
                     || chipMode == CHIP_FAILSAFE); // RULE_06 RULE_09

    flagSet = '0;
    flagSet[`FLAG_WAKE] = wakeOk;
    flagSet[`FLAG_CLAMP] = busTo; // RULE_13
    flagSet[`FLAG_SHORT] = faults.txRxShort; // RULE_14
    flagSet[`FLAG_BUS] = faults.busShort; // RULE_19
    // Set wins over a clear in the same cycle
    flags_nxt = (flags_r & ~flagClear) | flagSet;
    intN_nxt = ~|(flags_nxt & ~intMask); // RULE_13 RULE_14 RULE_19

    if (inhibit_nxt.txdTimeout) diagCode_nxt = DIAG_TXD_GND; // RULE_10
    else if (inhibit_nxt.txRxShort) diagCode_nxt = DIAG_TXRX_SHORT; // RULE_10
    else if (inhibit_nxt.rxdClamp) diagCode_nxt = DIAG_RXD_RECESSIVE;
    else if (inhibit_nxt.domClamp) diagCode_nxt = DIAG_DOM_CLAMP;
    else if (inhibit_nxt.overTemp) diagCode_nxt = DIAG_OVERTEMP;
    else if (flags_nxt[`FLAG_BUS]) diagCode_nxt = DIAG_BUS_SHORT;
    else diagCode_nxt = DIAG_NONE;

    // Driver needs normal mode, no latched inhibit and a healthy supply
    driverOk = (xcvrMode_nxt == XCVR_NORMAL) && !(|inhibit_nxt)
               && !faults.supplyLow && !faults.regUndervoltage; // RULE_01 RULE_18 RULE_25
    driveDominant_nxt = driverOk && !txdIn;
    busHiZ_nxt = faults.supplyLow || !driverOk; // RULE_02
    normalRxEn_nxt = !faults.supplyLow
                     && (xcvrMode_nxt == XCVR_NORMAL || xcvrMode_nxt == XCVR_RXONLY); // RULE_01
    wakeRxEn_nxt = !faults.supplyLow && (xcvrMode_nxt == XCVR_WAKE); // RULE_05
    splitEn_nxt = normalRxEn_nxt; // RULE_21
    // RxD is held low after a wake so the host sees it
    rxdOut_nxt = normalRxEn_nxt ? !busDominant : !flags_nxt[`FLAG_WAKE];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      xcvrMode_r <= XCVR_OFF;
      inhibit_r <= '0;
      flags_r <= `FLAG_RESET;
      armed_r <= 1'b1;
      txdPrev_r <= 1'b1;
      txdCnt_r <= '0;
      busCnt_r <= '0;
      diagCode_r <= DIAG_NONE;
      driveDominant_r <= 1'b0;
      busHiZ_r <= 1'b1;
      normalRxEn_r <= 1'b0;
      wakeRxEn_r <= 1'b0;
      splitEn_r <= 1'b0;
      rxdOut_r <= 1'b1;
      intN_r <= 1'b1;
      restartReq_r <= 1'b0;
    end else begin
      xcvrMode_r <= xcvrMode_nxt;
      inhibit_r <= inhibit_nxt;
      flags_r <= flags_nxt;
      armed_r <= armed_nxt;
      txdPrev_r <= txdPrev_nxt;
      txdCnt_r <= txdCnt_nxt;
      busCnt_r <= busCnt_nxt;
      diagCode_r <= diagCode_nxt;
      driveDominant_r <= driveDominant_nxt;
      busHiZ_r <= busHiZ_nxt;
      normalRxEn_r <= normalRxEn_nxt;
      wakeRxEn_r <= wakeRxEn_nxt;
      splitEn_r <= splitEn_nxt;
      rxdOut_r <= rxdOut_nxt;
      intN_r <= intN_nxt;
      restartReq_r <= restartReq_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  rxonly_no_drive_a: assert property ( // RULE_01
    xcvrMode_r == XCVR_RXONLY |-> !driveDominant_r && normalRxEn_r == !$past(faults.supplyLow))
    else $error("driver active or receiver off in receive-only");
  supply_off_passive_a: assert property ( // RULE_02
    faults.supplyLow |=> busHiZ_r && !driveDominant_r && !normalRxEn_r && !splitEn_r)
    else $error("bus not passive under low supply");
  mode_allowed_a: assert property ( // RULE_03
    ##1 allowed($past(chipMode), xcvrMode_r))
    else $error("transceiver mode not allowed in chip mode");
  sleep_wake_rx_a: assert property ( // RULE_05
    (chipMode == CHIP_SLEEP || chipMode == CHIP_STOP) && !faults.supplyLow
    |=> !normalRxEn_r && (wakeRxEn_r == (xcvrMode_r == XCVR_WAKE)))
    else $error("normal receiver on in low power chip mode");
  wake_restart_a: assert property ( // RULE_09
    busWake && xcvrMode_r == XCVR_WAKE && armed_r && (sleepCmdBusy || chipMode == CHIP_SLEEP)
    |=> restartReq_r && flags_r[`FLAG_WAKE] && !armed_r)
    else $error("wake in sleep did not request restart");
  off_ignores_wake_a: assert property ( // RULE_23
    busWake && xcvrMode_r == XCVR_OFF |=> !restartReq_r)
    else $error("wake accepted in off mode");
  txd_timeout_a: assert property ( // RULE_12
    !txdIn [*2] ##0 (txdCnt_r == TW'(TXD_TO_CYC - 1))
    |=> inhibit_r.txdTimeout && !driveDominant_r && diagCode_r == DIAG_TXD_GND)
    else $error("txd time-out did not stop driver");
  bus_clamp_a: assert property ( // RULE_13
    busDominant && busCnt_r == BW'(BUS_TO_CYC - 1) && chipMode == CHIP_NORMAL
    |=> inhibit_r.domClamp && xcvrMode_r == XCVR_RXONLY && flags_r[`FLAG_CLAMP]
        && (intN_r == intMask[`FLAG_CLAMP] || !intMask[`FLAG_CLAMP] && !intN_r))
    else $error("bus clamp not handled");
  bus_fault_flag_a: assert property ( // RULE_19
    faults.busShort && !intMask[`FLAG_BUS] |=> flags_r[`FLAG_BUS] && !intN_r
    && xcvrMode_r == $past(xcvrMode_r) || $past(reqOk) || !allowed($past(chipMode), $past(xcvrMode_r)))
    else $error("bus fault flag or interrupt missing");
  split_mode_a: assert property ( // RULE_21
    splitEn_r == ((xcvrMode_r == XCVR_NORMAL || xcvrMode_r == XCVR_RXONLY) && !$past(faults.supplyLow)))
    else $error("split output wrong for mode");
  inhibit_gates_a: assert property ( // RULE_25
    |inhibit_r |-> !driveDominant_r)
    else $error("driver active with inhibit latched");
  overtemp_release_a: assert property ( // RULE_16
    inhibit_r.overTemp && !faults.overTemp && txdIn && !txdPrev_r |=> !inhibit_r.overTemp)
    else $error("overtemp inhibit not released on recessive edge");

  timeout_code_a: assert property ( // RULE_10
    inhibit_r.txdTimeout |-> diagCode_r == DIAG_TXD_GND)
    else $error("txd time-out not reported as txd ground");

  short_code_a: assert property ( // RULE_10
    inhibit_r.txRxShort && !inhibit_r.txdTimeout |-> diagCode_r == DIAG_TXRX_SHORT)
    else $error("txd-rxd short not reported");

  short_inhibit_a: assert property ( // RULE_14
    faults.txRxShort |=> inhibit_r.txRxShort && flags_r[`FLAG_SHORT] && !driveDominant_r)
    else $error("txd-rxd short did not inhibit driver");

  short_int_a: assert property ( // RULE_14
    faults.txRxShort && !intMask[`FLAG_SHORT] |=> !intN_r)
    else $error("txd-rxd short did not raise interrupt");

  clamp_int_a: assert property ( // RULE_13
    flags_r[`FLAG_CLAMP] && !$past(intMask[`FLAG_CLAMP]) |-> !intN_r)
    else $error("unmasked clamp flag without interrupt");

  overtemp_off_a: assert property ( // RULE_16
    faults.overTemp |=> inhibit_r.overTemp && !driveDominant_r && busHiZ_r)
    else $error("driver active during overtemperature");

  rxd_clamp_hold_a: assert property ( // RULE_17
    inhibit_r.rxdClamp && !(modeReqValid && modeReq == XCVR_NORMAL) |=> inhibit_r.rxdClamp)
    else $error("rxd clamp inhibit released without normal request");

  undervoltage_off_a: assert property ( // RULE_18
    faults.regUndervoltage |=> busHiZ_r && !driveDominant_r)
    else $error("driver active under regulator undervoltage");

  supply_rx_off_a: assert property ( // RULE_02
    faults.supplyLow |=> !wakeRxEn_r)
    else $error("wake receiver on under low supply");

  bus_short_mode_a: assert property ( // RULE_19
    faults.busShort && !modeReqValid && txdIn && !busDominant && !faults.txRxShort
    && allowed(chipMode, xcvrMode_r) |=> xcvrMode_r == $past(xcvrMode_r))
    else $error("bus fault changed transceiver mode");

  split_off_a: assert property ( // RULE_21
    xcvrMode_r == XCVR_WAKE || xcvrMode_r == XCVR_OFF |-> !splitEn_r)
    else $error("split output on in wake-capable or off");

  restart_pulse_a: assert property ( // RULE_06
    restartReq_r |=> !restartReq_r)
    else $error("restart request longer than one cycle");

  wake_rearm_a: assert property ( // RULE_22
    !armed_r && modeReqValid && modeReq == XCVR_WAKE && xcvrMode_r != XCVR_WAKE
    && chipMode == CHIP_NORMAL |=> xcvrMode_r != XCVR_WAKE)
    else $error("wake-capable re-armed without another mode");

  txd_restart_a: assert property ( // RULE_24
    txdIn |=> txdCnt_r == '0)
    else $error("txd counter not restarted on recessive");

  bus_restart_a: assert property ( // RULE_24
    !busDominant |=> busCnt_r == '0)
    else $error("bus counter not restarted on recessive");

  driver_gate_a: assert property ( // RULE_25
    driveDominant_r |-> xcvrMode_r == XCVR_NORMAL && !(|inhibit_r))
    else $error("driver active outside normal mode");

  // ****************************************
  // Cover points
  // ****************************************
  wake_seen_c: cover property (busWake && xcvrMode_r == XCVR_WAKE && armed_r ##1 restartReq_r);
  clamp_seen_c: cover property (inhibit_r.domClamp ##[1:20] !inhibit_r.domClamp);
  drive_seen_c: cover property (driveDominant_r ##1 !driveDominant_r);
  short_seen_c: cover property (faults.txRxShort ##1 inhibit_r.txRxShort);
  overtemp_seen_c: cover property (inhibit_r.overTemp ##1 !inhibit_r.overTemp);

endmodule : can_transceiver_mode_supervisor

// ---- hw/can_xcvr_cfg.svh ----
`ifndef CAN_XCVR_CFG_SVH
`define CAN_XCVR_CFG_SVH

// ****************************************
// Clock and time-outs
// ****************************************
`define CLK_PERIOD_NS 4
`define TXD_TIMEOUT_NS 100000
`define BUS_TIMEOUT_NS 100000
// Least times: round up to whole cycles
`define TXD_TIMEOUT_CYC ((`TXD_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUS_TIMEOUT_CYC ((`BUS_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Event flag positions and reset values
// ****************************************
`define FLAG_WAKE 0
`define FLAG_CLAMP 1
`define FLAG_SHORT 2
`define FLAG_BUS 3
`define FLAG_COUNT 4
`define FLAG_RESET 4'h0

`endif

// ---- hw/can_xcvr_pkg.sv ----
package can_xcvr_pkg;

  // ****************************************
  // Modes
  // ****************************************
  typedef enum logic [2:0] {
    CHIP_INIT, CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP,
    CHIP_RESTART, CHIP_FAILSAFE, CHIP_SWFLASH
  } chip_mode_e;

  typedef enum logic [1:0] {XCVR_OFF, XCVR_WAKE, XCVR_NORMAL, XCVR_RXONLY} xcvr_mode_e;

  typedef enum logic [2:0] {
    DIAG_NONE, DIAG_TXD_GND, DIAG_TXRX_SHORT, DIAG_RXD_RECESSIVE,
    DIAG_DOM_CLAMP, DIAG_OVERTEMP, DIAG_BUS_SHORT
  } diag_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic supplyLow;
    logic regUndervoltage;
    logic overTemp;
    logic txRxShort;
    logic busShort;
  } fault_in_s;

  typedef struct packed {
    logic txdTimeout;
    logic domClamp;
    logic txRxShort;
    logic rxdClamp;
    logic overTemp;
  } inhibit_s;

endpackage : can_xcvr_pkg

// ---- tb/can_host_model.sv ----
`timescale 1ns/100ps
// ****************************************
// Host controller: drives TxD, checks echo
// ****************************************
module can_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Bench command and pins
  input wire logic sendDominant,
  input wire logic rxd,
  output logic txd,
  output logic echoMiss
);
  // TxD recessive out of reset so the node never blocks the bus
  always_ff @(posedge clock) begin
    if (rst) begin
      txd <= 1'b1;
      echoMiss <= 1'b0;
    end else begin
      txd <= !sendDominant;
      echoMiss <= !txd && rxd;
    end
  end
endmodule : can_host_model

// ---- tb/can_transceiver_mode_supervisor_tb.sv ----
`timescale 1ns/100ps
`include "can_xcvr_cfg.svh"
module can_transceiver_mode_supervisor_tb
  import can_xcvr_pkg::*;
;
  logic clock = 0, rst = 1, sleepCmdBusy = 0, modeReqValid = 0, busDominant = 0;
  logic rxdSense = 1, busWake = 0, sendDominant = 0, txdIn, echoMiss;
  chip_mode_e chipMode = CHIP_INIT;
  xcvr_mode_e modeReq = XCVR_OFF, expMode;
  logic [`FLAG_COUNT-1:0] flagClear = '0, intMask = '0;
  fault_in_s faults = '0;
  logic driveDominant_r, normalRxEn_r, wakeRxEn_r, busHiZ_r, splitEn_r, rxdOut_r, intN_r;
  logic restartReq_r;
  xcvr_mode_e xcvrMode_r;
  diag_e diagCode_r;
  inhibit_s inhibit_r;
  logic [`FLAG_COUNT-1:0] flags_r;
  int badCount = 0, checksDone = 0, cycles = 0;
  always #2 clock = !clock;
  // Short time-outs keep the run brief
  can_transceiver_mode_supervisor #(.TXD_TO_CYC(8), .BUS_TO_CYC(8)) dut (.*);
  can_host_model host (.clock(clock), .rst(rst), .sendDominant(sendDominant), .rxd(rxdOut_r),
    .txd(txdIn), .echoMiss(echoMiss));
  task automatic summarize();
    $display("Checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      badCount++;
      summarize();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("Error %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  task automatic req(input xcvr_mode_e m);
    @(posedge clock);
    modeReqValid <= 1'b1;
    modeReq <= m;
    @(posedge clock);
    modeReqValid <= 1'b0;
    #1;
  endtask : req
  task automatic clr(input logic [3:0] v);
    @(posedge clock);
    flagClear <= v;
    @(posedge clock);
    flagClear <= '0;
  endtask : clr
  task automatic wake();
    @(posedge clock);
    busWake <= 1'b1;
    @(posedge clock);
    busWake <= 1'b0;
    #1;
  endtask : wake
  task automatic txd(input int n, input logic v);
    @(posedge clock);
    sendDominant <= v;
    tick(n);
  endtask : txd
  function automatic bit allowed(input int c, input int m);
    case (c)
      0: return m == 0;
      1: return 1;
      5: return m == 1;
      6: return m == 2;
      default: return m < 2;
    endcase
  endfunction : allowed
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    tick(1);
    chk(xcvrMode_r, XCVR_OFF, "reset mode");
    chk({busHiZ_r, splitEn_r, rxdOut_r, intN_r}, 4'hB, "reset pins");
    chk({flags_r, inhibit_r, diagCode_r}, 12'h000, "reset state");
    expMode = XCVR_OFF;
    for (int c = 0; c < 7; c++) begin
      @(posedge clock);
      chipMode <= chip_mode_e'(c);
      tick(2);
      if (!allowed(c, expMode))
        expMode = (c == 0) ? XCVR_OFF : (c == 6) ? XCVR_NORMAL : XCVR_WAKE;
      chk(xcvrMode_r, expMode, "coerced mode");
      for (int m = 0; m < 4; m++) begin
        req(xcvr_mode_e'(m));
        if (allowed(c, m))
          expMode = xcvr_mode_e'(m);
        chk(xcvrMode_r, expMode, "mode table");
        chk(splitEn_r, expMode[1], "split");
      end
    end
    @(posedge clock);
    chipMode <= CHIP_NORMAL;
    req(XCVR_NORMAL);
    txd(6, 1);
    txd(2, 0);
    txd(6, 1);
    chk(inhibit_r.txdTimeout, 0, "timeout restart");
    tick(8);
    chk(inhibit_r.txdTimeout, 1, "txd timeout");
    chk(driveDominant_r, 0, "driver stopped");
    chk(diagCode_r, DIAG_TXD_GND, "timeout code");
    chk(xcvrMode_r, XCVR_RXONLY, "auto rx only");
    txd(3, 0);
    req(XCVR_NORMAL);
    chk(inhibit_r, 5'h00, "timeout release");
    @(posedge clock);
    busDominant <= 1'b1;
    rxdSense <= 1'b0;
    tick(14);
    chk({flags_r[`FLAG_CLAMP], inhibit_r.domClamp, intN_r}, 3'h6, "clamp");
    chk(xcvrMode_r, XCVR_RXONLY, "clamp mode");
    chk(diagCode_r, DIAG_DOM_CLAMP, "clamp code");
    @(posedge clock);
    intMask <= 4'h2;
    tick(2);
    chk(intN_r, 1, "masked");
    busDominant <= 1'b0;
    rxdSense <= 1'b1;
    intMask <= 4'h0;
    clr(4'h2);
    req(XCVR_NORMAL);
    chk({inhibit_r, xcvrMode_r}, {5'h00, XCVR_NORMAL}, "clamp release");
    @(posedge clock);
    busDominant <= 1'b1;
    tick(3);
    chk({inhibit_r.rxdClamp, busHiZ_r}, 2'h3, "rxd clamp");
    chk(diagCode_r, DIAG_RXD_RECESSIVE, "rxd code");
    busDominant <= 1'b0;
    tick(3);
    chk(inhibit_r.rxdClamp, 1, "rxd clamp held");
    req(XCVR_NORMAL);
    chk(inhibit_r, 5'h00, "rxd release");
    @(posedge clock);
    faults.txRxShort <= 1'b1;
    tick(3);
    chk({inhibit_r.txRxShort, flags_r[`FLAG_SHORT], intN_r}, 3'h6, "short");
    chk({xcvrMode_r, diagCode_r}, {XCVR_RXONLY, DIAG_TXRX_SHORT}, "short mode");
    faults.txRxShort <= 1'b0;
    faults.supplyLow <= 1'b1;
    tick(2);
    chk({busHiZ_r, splitEn_r}, 2'h2, "supply cut");
    faults.supplyLow <= 1'b0;
    clr(4'h4);
    req(XCVR_NORMAL);
    chk({inhibit_r, intN_r}, 6'h01, "short release");
    @(posedge clock);
    faults.busShort <= 1'b1;
    tick(3);
    chk({flags_r[`FLAG_BUS], intN_r}, 2'h2, "bus short");
    chk({xcvrMode_r, diagCode_r}, {XCVR_NORMAL, DIAG_BUS_SHORT}, "bus short mode");
    faults.busShort <= 1'b0;
    clr(4'h8);
    faults.overTemp <= 1'b1;
    tick(3);
    chk({inhibit_r.overTemp, busHiZ_r}, 2'h3, "overtemp");
    chk(xcvrMode_r, XCVR_NORMAL, "overtemp mode");
    faults.overTemp <= 1'b0;
    tick(3);
    chk(inhibit_r.overTemp, 1, "no edge yet");
    txd(3, 1);
    txd(4, 0);
    chk(inhibit_r.overTemp, 0, "edge release");
    txd(3, 1);
    chk({driveDominant_r, busHiZ_r}, 2'h2, "driving");
    chk(echoMiss, 1, "echo missing");
    faults.supplyLow <= 1'b1;
    tick(3);
    chk({driveDominant_r, busHiZ_r}, 2'h1, "supply low");
    faults.supplyLow <= 1'b0;
    txd(3, 0);
    faults.regUndervoltage <= 1'b1;
    tick(3);
    chk(busHiZ_r, 1, "regulator low");
    req(XCVR_OFF);
    chk({xcvrMode_r, splitEn_r}, {XCVR_OFF, 1'b0}, "host off");
    faults.regUndervoltage <= 1'b0;
    req(XCVR_RXONLY);
    txd(3, 1);
    chk({driveDominant_r, normalRxEn_r}, 2'h1, "rx only");
    txd(3, 0);
    // ****************************************
    // Wake handling
    // ****************************************
    req(XCVR_WAKE);
    sleepCmdBusy <= 1'b1;
    wake();
    chk({restartReq_r, flags_r[`FLAG_WAKE], rxdOut_r}, 3'h6, "wake in sleep cmd");
    tick(1);
    chk(restartReq_r, 0, "restart pulse");
    sleepCmdBusy <= 1'b0;
    clr(4'h1);
    wake();
    chk(flags_r[`FLAG_WAKE], 0, "disarmed");
    req(XCVR_OFF);
    req(XCVR_WAKE);
    chk(xcvrMode_r, XCVR_WAKE, "rearmed");
    @(posedge clock);
    chipMode <= CHIP_SLEEP;
    tick(2);
    chk({wakeRxEn_r, normalRxEn_r}, 2'h2, "wake receiver");
    wake();
    chk({restartReq_r, flags_r[`FLAG_WAKE]}, 2'h3, "sleep wake");
    chipMode <= CHIP_NORMAL;
    clr(4'h1);
    req(XCVR_OFF);
    wake();
    tick(1);
    chk({restartReq_r, flags_r[`FLAG_WAKE]}, 2'h0, "off ignores wake");
    summarize();
  end
endmodule : can_transceiver_mode_supervisor_tb
